/* rtl/cbt_defs.svh */
// Named constants for the CAN bit timing block.
// Assumes all quanta figures are 5-bit wide and the bus is active-low dominant.
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH

// One quantum: length of the sync segment and the field offset
`define CBT_ONE_TQ 5'h01
// Fixed processing interval after the sample point
`define CBT_PROC_TQ 5'h02
// Legal span of the nominal bit time
`define CBT_BIT_MIN_TQ 5'h08
`define CBT_BIT_MAX_TQ 5'h19
// Bus levels
`define CBT_RECESSIVE 1'b1
`define CBT_DOMINANT 1'b0
// Counter clear values
`define CBT_CNT_ZERO 5'h00
`define CBT_PRESC_ZERO 6'h00

`endif

/* rtl/cbt_pkg.sv */
// Types shared by the CAN bit timing block and its surroundings.
// Assumes the defs header supplies all numeric constants.
package cbt_pkg;

  // Bit timing settings as written by the configuring host
  typedef struct packed {
    logic [5:0] quantum_prescale;
    logic [1:0] jump_width;
    logic [2:0] propagation_length;
    logic [2:0] first_phase_length;
    logic [2:0] second_phase_length;
    logic triple_sample_select;
    logic second_phase_source;
  } cbt_timing_cfg_t;

  // Segments of the nominal bit
  typedef enum logic [2:0] {
    CBT_IDLE = 3'b000,
    CBT_SYNC = 3'b001,
    CBT_PROP = 3'b010,
    CBT_PH1 = 3'b011,
    CBT_PH2 = 3'b100
  } cbt_seg_t;

  // State reported to the protocol engine
  typedef struct packed {
    cbt_seg_t segment;
    logic [4:0] bit_quanta;
    logic bit_quanta_ok;
    logic hard_sync;
    logic resync;
  } cbt_status_t;

endpackage

/* rtl/cbt_bit_timing.sv */
// Bit timing and digital phase tracker of a CAN controller.
// Assumes one oscillator clock, an asynchronous receive pin, and a protocol
// engine on the same clock that reports bus idle and own dominant transmission.
`timescale 1ns/1ps
`include "cbt_defs.svh"

module cbt_bit_timing
  import cbt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Configuration from the host register file
  input wire logic config_mode,
  input wire cbt_timing_cfg_t timing_cfg,
  // Protocol engine hints
  input wire logic bus_idle,
  input wire logic transmitting_dominant,
  // Transceiver receive pin
  input wire logic bus_receive_line,
  // Bit stream to the protocol engine
  output logic sample_strobe,
  output logic sample_value,
  output logic bit_start,
  output cbt_status_t status
);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Larger of two quanta counts
  function automatic logic [4:0] cbt_max(input logic [4:0] a, input logic [4:0] b);
    cbt_max = (a > b) ? a : b;
  endfunction

  cbt_timing_cfg_t cfg; // Settings in force
  logic rx_meta; // First synchroniser stage
  logic rx_sync; // Second synchroniser stage
  logic rx_prev; // Previous synchronised level
  cbt_seg_t seg; // Current segment
  logic [4:0] seg_cnt; // Whole quanta elapsed in segment
  logic [5:0] presc_cnt; // Oscillator cycles in half quantum
  logic half_phase; // Second half of the quantum
  logic [4:0] ph1_ext; // Lengthening of first phase
  logic [4:0] ph2_cut; // Shortening of second phase
  logic synced_bit; // A sync already took place this bit
  logic last_sample; // Bus value at previous sample point
  logic [1:0] early_samples; // Samples at SP-Tq and SP-Tq/2

  // Next values
  cbt_seg_t next_seg;
  logic [4:0] next_cnt;
  logic [4:0] next_ext;
  logic [4:0] next_cut;
  logic next_synced;
  logic next_bit_start;

  // Settings are frozen outside configuration mode so that a host write
  // during traffic cannot tear a bit in half.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cfg <= '0;
    else if (config_mode)
      cfg <= timing_cfg;
  end

  // Two-stage synchroniser on the pin, then one stage for edge detection
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_meta <= `CBT_RECESSIVE;
      rx_sync <= `CBT_RECESSIVE;
      rx_prev <= `CBT_RECESSIVE;
    end
    else
    begin
      rx_meta <= bus_receive_line;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // Segment lengths in quanta
  wire [4:0] prop_len = {2'b00, cfg.propagation_length} + `CBT_ONE_TQ;
  wire [4:0] ph1_len = {2'b00, cfg.first_phase_length} + `CBT_ONE_TQ;
  wire [4:0] ph2_field = {2'b00, cfg.second_phase_length} + `CBT_ONE_TQ;
  wire [4:0] jump_tq = {3'b000, cfg.jump_width} + `CBT_ONE_TQ;
  // Field mode still honours the two-quantum processing floor
  wire [4:0] ph2_len = cfg.second_phase_source ? cbt_max(ph2_field, `CBT_PROC_TQ)
                                               : cbt_max(ph1_len, `CBT_PROC_TQ);
  // Nominal bit length; the host is trusted to keep it in range and rate
  wire [4:0] bit_quanta = `CBT_ONE_TQ + prop_len + ph1_len + ph2_len;
  wire bit_quanta_ok = (bit_quanta >= `CBT_BIT_MIN_TQ) && (bit_quanta <= `CBT_BIT_MAX_TQ);

  // Prescaler: half a quantum is prescale+1 oscillator cycles
  wire half_tick = (seg != CBT_IDLE) && (presc_cnt == cfg.quantum_prescale);
  wire tq_tick = half_tick && half_phase;

  // Only a recessive-to-dominant edge carries timing
  wire fall_edge = (rx_prev == `CBT_RECESSIVE) && (rx_sync == `CBT_DOMINANT);
  // Edge counts only if it changes the value seen at the last sample point,
  // and only once per bit
  wire sync_ok = fall_edge && (last_sample == `CBT_RECESSIVE) && !synced_bit;

  // Where the edge fell
  wire in_pos = (seg == CBT_PROP) || (seg == CBT_PH1);
  wire in_neg = (seg == CBT_PH2);
  // Positive error: quanta since sync end; negative: quanta left in the bit
  wire [4:0] pos_err = (seg == CBT_PROP) ? (seg_cnt + `CBT_ONE_TQ)
                                         : (prop_len + seg_cnt + `CBT_ONE_TQ);
  wire [4:0] ph2_end = ph2_len - ph2_cut;
  wire [4:0] neg_err = ph2_end - seg_cnt;

  // Hard sync while idle; bars resync in the same bit
  wire hard = sync_ok && ((seg == CBT_IDLE) || bus_idle);
  // Resync candidates; an edge in the sync segment has zero error
  wire resync_ok = sync_ok && !hard && ((in_pos && !transmitting_dominant) || in_neg);
  wire small_err = (in_pos && (pos_err <= jump_tq)) || (in_neg && (neg_err <= jump_tq));
  wire restart = hard || (resync_ok && small_err);
  wire lengthen = resync_ok && in_pos && !small_err;
  wire shorten = resync_ok && in_neg && !small_err;

  // Effective first phase end includes a lengthening taken this cycle
  wire [4:0] ext_now = lengthen ? jump_tq : ph1_ext;
  wire [4:0] cut_now = shorten ? jump_tq : ph2_cut;
  wire [4:0] ph1_end = ph1_len + ext_now;
  wire [4:0] ph2_stop = ph2_len - cut_now;

  // Length of the running segment
  wire [4:0] cur_len = (seg == CBT_SYNC) ? `CBT_ONE_TQ :
                       (seg == CBT_PROP) ? prop_len :
                       (seg == CBT_PH1) ? ph1_end : ph2_stop;
  wire seg_done = tq_tick && ((seg_cnt + `CBT_ONE_TQ) == cur_len);

  // Sample point is the end of the first phase
  wire samp_now = seg_done && (seg == CBT_PH1) && !restart;
  // Majority of the samples at SP-Tq, SP-Tq/2 and SP
  wire majority = (early_samples[1] & early_samples[0]) |
                  (early_samples[1] & rx_sync) |
                  (early_samples[0] & rx_sync);
  wire samp_val = cfg.triple_sample_select ? majority : rx_sync;

  // Segment sequencing and phase adjustment
  always_comb
  begin
    next_seg = seg;
    next_cnt = seg_cnt;
    next_ext = ph1_ext;
    next_cut = ph2_cut;
    next_synced = synced_bit;
    next_bit_start = 1'b0;
    if (restart)
    begin
      // Edge now lies in a fresh sync segment
      next_seg = CBT_SYNC;
      next_cnt = `CBT_CNT_ZERO;
      next_ext = `CBT_CNT_ZERO;
      next_cut = `CBT_CNT_ZERO;
      next_synced = 1'b1;
      next_bit_start = 1'b1;
    end
    else
    begin
      // Adjustments last until the end of this bit
      if (lengthen)
      begin
        next_ext = jump_tq;
        next_synced = 1'b1;
      end
      if (shorten)
      begin
        next_cut = jump_tq;
        next_synced = 1'b1;
      end
      if (seg_done)
      begin
        next_cnt = `CBT_CNT_ZERO;
        case (seg)
          CBT_SYNC: next_seg = CBT_PROP;
          CBT_PROP: next_seg = CBT_PH1;
          CBT_PH1: next_seg = CBT_PH2;
          CBT_PH2:
          begin
            // Bit ends: adjustments and sync lock expire
            next_seg = CBT_SYNC;
            next_ext = `CBT_CNT_ZERO;
            next_cut = `CBT_CNT_ZERO;
            next_synced = 1'b0;
            next_bit_start = 1'b1;
          end
          default: next_seg = CBT_IDLE;
        endcase
      end
      else if (tq_tick)
        next_cnt = seg_cnt + `CBT_ONE_TQ;
    end
  end

  // Segment state; held idle from reset until the first hard sync
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seg <= CBT_IDLE;
      seg_cnt <= `CBT_CNT_ZERO;
      ph1_ext <= `CBT_CNT_ZERO;
      ph2_cut <= `CBT_CNT_ZERO;
      synced_bit <= 1'b0;
    end
    else
    begin
      seg <= next_seg;
      seg_cnt <= next_cnt;
      ph1_ext <= next_ext;
      ph2_cut <= next_cut;
      synced_bit <= next_synced;
    end
  end

  // Prescaler restarts with the bit so the edge sits at the quantum start
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_cnt <= `CBT_PRESC_ZERO;
      half_phase <= 1'b0;
    end
    else if (restart || (seg == CBT_IDLE))
    begin
      presc_cnt <= `CBT_PRESC_ZERO;
      half_phase <= 1'b0;
    end
    else if (half_tick)
    begin
      presc_cnt <= `CBT_PRESC_ZERO;
      half_phase <= !half_phase;
    end
    else
      presc_cnt <= presc_cnt + 6'h01;
  end

  // Half-quantum sample history for triple sampling
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      early_samples <= {`CBT_RECESSIVE, `CBT_RECESSIVE};
    else if (half_tick)
      early_samples <= {early_samples[0], rx_sync};
  end

  // Sampled bit; recessive until the first sample so an idle bus reads idle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      last_sample <= `CBT_RECESSIVE;
    else if (samp_now)
      last_sample <= samp_val;
  end

  // Registered strobes and status toward the protocol engine
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sample_strobe <= 1'b0;
      bit_start <= 1'b0;
      status <= '0;
    end
    else
    begin
      sample_strobe <= samp_now;
      bit_start <= next_bit_start;
      status.segment <= next_seg;
      status.bit_quanta <= bit_quanta;
      status.bit_quanta_ok <= bit_quanta_ok;
      status.hard_sync <= hard;
      status.resync <= resync_ok;
    end
  end

  // The strobe value is the flop that also feeds edge qualification
  assign sample_value = last_sample;

  property p_sync_one_tq;
    (seg == CBT_SYNC && tq_tick && !restart) |=> (seg == CBT_PROP);
  endproperty
  a_sync_one_tq: assert property (p_sync_one_tq) else $error("sync segment not one quantum");

  property p_cfg_frozen;
    !config_mode |=> $stable(cfg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("settings changed outside config");

  property p_sample_at_ph1_end;
    sample_strobe |-> (seg == CBT_PH2) && $past(seg) == CBT_PH1;
  endproperty
  a_sample_at_ph1_end: assert property (p_sample_at_ph1_end) else $error("sample not at phase one end");

  property p_ph2_floor;
    (seg == CBT_PH2) && seg_done && !shorten && (ph2_cut == `CBT_CNT_ZERO) |-> (seg_cnt >= `CBT_ONE_TQ);
  endproperty
  a_ph2_floor: assert property (p_ph2_floor) else $error("second phase below processing time");

  property p_one_sync_per_bit;
    (status.hard_sync || status.resync) |-> !((hard || resync_ok) && !bit_start);
  endproperty
  a_one_sync_per_bit: assert property (p_one_sync_per_bit) else $error("two syncs in one bit");

  property p_idle_counters;
    (seg == CBT_IDLE) |-> (presc_cnt == `CBT_PRESC_ZERO) && (seg_cnt == `CBT_CNT_ZERO) && !sample_strobe;
  endproperty
  a_idle_counters: assert property (p_idle_counters) else $error("counters run while idle");

  property p_rising_ignored;
    (rx_prev == `CBT_DOMINANT && rx_sync == `CBT_RECESSIVE) |=> !status.hard_sync && !status.resync;
  endproperty
  a_rising_ignored: assert property (p_rising_ignored) else $error("sync on rising edge");

  property p_no_pos_resync_tx;
    (transmitting_dominant && in_pos && !bus_idle) |=> !status.resync && $stable(ph1_ext) || bit_start;
  endproperty
  a_no_pos_resync_tx: assert property (p_no_pos_resync_tx) else $error("positive resync while sending");

  property p_quantum_period;
    (tq_tick && !restart && seg == CBT_PROP) |-> ##1 (!tq_tick || restart) [*1] ##0 (presc_cnt == `CBT_PRESC_ZERO);
  endproperty
  a_quantum_period: assert property (p_quantum_period) else $error("prescaler not cleared after tick");

  property p_lengthen_jump;
    lengthen |=> (ph1_ext == $past(jump_tq)) || bit_start;
  endproperty
  a_lengthen_jump: assert property (p_lengthen_jump) else $error("phase one not lengthened by jump");

  property p_shorten_jump;
    shorten |=> (ph2_cut == $past(jump_tq)) || bit_start;
  endproperty
  a_shorten_jump: assert property (p_shorten_jump) else $error("phase two not shortened by jump");

endmodule

/* tb/cbt_bus_node.sv */
// Bus node model: stands for the transceiver and the other nodes on the wire.
// Assumes the bench calls its task just after a rising clock edge.
`timescale 1ns/1ps
module cbt_bus_node
(
  // Clock of the far node's bit engine
  input wire logic clock,
  // Receive line, 1 is recessive
  output logic line
);
  // Termination holds the bus recessive until a node pulls it
  initial line = 1'b1;

  // Change the line level on the d-th rising edge from now
  task automatic drive_after(input int d, input logic lvl);
    begin
      repeat (d) @(posedge clock);
      line <= lvl;
    end
  endtask
endmodule

/* tb/cbt_bit_timing_tb.sv */
// Testbench for the CAN bit timing block.
// Assumes a 250 MHz clock and the bus node model on the receive pin.
`timescale 1ns/1ps
module cbt_bit_timing_tb
  import cbt_pkg::*;
;
  // Stimulus towards the block
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic config_mode = 1'b0;
  cbt_timing_cfg_t timing_cfg = '0;
  logic bus_idle = 1'b1;
  logic transmitting_dominant = 1'b0;
  logic bus_receive_line;
  // Observed outputs
  logic sample_strobe;
  logic sample_value;
  logic bit_start;
  cbt_status_t status;
  // Bookkeeping
  int err_count = 0;
  int compares = 0;
  int sync_count = 0;
  int n;

  always #2 clock = ~clock;

  cbt_bit_timing i_cbt_bit_timing (
    .clock(clock), .rst_n(rst_n), .config_mode(config_mode), .timing_cfg(timing_cfg),
    .bus_idle(bus_idle), .transmitting_dominant(transmitting_dominant),
    .bus_receive_line(bus_receive_line), .sample_strobe(sample_strobe),
    .sample_value(sample_value), .bit_start(bit_start), .status(status)
  );

  cbt_bus_node i_cbt_bus_node (
    .clock(clock),
    .line(bus_receive_line)
  );

  // Count synchronisation pulses mid-cycle, away from the launching edge
  always @(negedge clock)
    if (status.hard_sync === 1'b1 || status.resync === 1'b1)
      sync_count = sync_count + 1;

  // Compare one value and log a mismatch
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      compares++;
      if (seen !== exp)
      begin
        err_count++;
        $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic report_and_stop;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // Let n edges pass, then look once the updates have landed
  task automatic tick(input int cnt);
    begin
      repeat (cnt) @(posedge clock);
      #1;
    end
  endtask

  // Count edges to the next sample point or bit start, bounded so a hang shows
  task automatic wait_event(output int cnt);
    begin
      cnt = 0;
      do
      begin
        tick(1);
        cnt++;
      end while (sample_strobe !== 1'b1 && bit_start !== 1'b1 && cnt < 400);
    end
  endtask

  // Load one setting and check the bit length it yields
  task automatic load_cfg(input logic [2:0] prop, input logic [2:0] ph1, input logic [2:0] ph2, input logic src);
    logic [4:0] p2;
    logic [4:0] q;
    begin
      // Second phase never under the two quanta of processing time
      p2 = (src ? ph2 : ph1) == 3'h0 ? 5'h02 : {2'h0, src ? ph2 : ph1} + 5'h01;
      q = 5'h03 + {2'h0, prop} + {2'h0, ph1} + p2;
      @(posedge clock);
      config_mode <= 1'b1;
      // Quantum of 32 clocks keeps every bit of 8 quanta or more at 1 us or longer
      timing_cfg <= '{6'h0f, 2'h1, prop, ph1, ph2, 1'b1, src};
      @(posedge clock);
      config_mode <= 1'b0;
      tick(3);
      check(status.bit_quanta, q, "bit length");
      check(status.bit_quanta_ok, q >= 5'h08 && q <= 5'h19, "bit length range");
      $display("Config test done at %0t", $time);
    end
  endtask

  // One bit: move the line at two offsets, then time sample point and bit end
  task automatic run_row(input int d1, input logic l1, input int d2, input logic l2, input logic txd,
                         input logic idle, input int e1, input logic restart, input logic val,
                         input int e2, input int syncs);
    int m;
    int s0;
    begin
      s0 = sync_count;
      fork
        begin
          @(posedge clock);
          transmitting_dominant <= txd;
          bus_idle <= idle;
          i_cbt_bus_node.drive_after(d1 - 1, l1);
          if (d2 > d1)
            i_cbt_bus_node.drive_after(d2 - d1, l2);
        end
        begin
          wait_event(m);
          check(m, e1, "bit start to next event");
          check(bit_start, restart, "restart at edge");
          if (!restart)
          begin
            check(sample_value, val, "sampled level");
            wait_event(m);
            check(m, e2, "sample point to bit end");
          end
        end
      join
      // Pulses of the closing edge are counted at the following falling edge
      @(negedge clock);
      #1;
      check(sync_count - s0, syncs, "synchronisations");
      $display("Bit test done at %0t", $time);
    end
  endtask

  // Watchdog, a few times the expected length of the run
  initial
  begin
    #80000;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop;
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    tick(4);
    check(status.segment, CBT_IDLE, "idle after reset");
    check({sample_strobe, bit_start, sample_value}, 3'b001, "strobes after reset");
    $display("Reset test done at %0t", $time);
    load_cfg(3'h3, 3'h2, 3'h0, 1'b1);
    load_cfg(3'h7, 3'h7, 3'h7, 1'b1);
    load_cfg(3'h7, 3'h7, 3'h0, 1'b0);
    load_cfg(3'h2, 3'h0, 3'h5, 1'b0);
    // Run setting: 1+2+4+3 quanta, jump width 2, triple sampling; never under 8 quanta
    load_cfg(3'h1, 3'h3, 3'h2, 1'b1);
    @(posedge clock);
    timing_cfg <= '0;
    tick(3);
    check(status.bit_quanta, 5'h0a, "write outside configuration");
    check(status.segment, CBT_IDLE, "still idle without edge");
    // First falling edge while idle starts the bit timing
    i_cbt_bus_node.drive_after(1, 1'b0);
    wait_event(n);
    check(n, 3, "hard sync delay");
    check(status.hard_sync, 1'b1, "hard sync flag");
    check(status.segment, CBT_SYNC, "segment after hard sync");
    $display("Hard sync test done at %0t", $time);
    @(negedge clock);
    #1;
    run_row(10, 1'b1, 50, 1'b0, 1'b0, 1'b1, 224, 1'b0, 1'b0, 96, 0);
    run_row(216, 1'b1, 216, 1'b1, 1'b0, 1'b0, 224, 1'b0, 1'b0, 96, 0);
    run_row(5, 1'b1, 5, 1'b1, 1'b0, 1'b0, 224, 1'b0, 1'b1, 96, 0);
    run_row(70, 1'b0, 70, 1'b0, 1'b0, 1'b0, 73, 1'b1, 1'b0, 0, 1);
    run_row(5, 1'b0, 5, 1'b0, 1'b0, 1'b0, 224, 1'b0, 1'b0, 96, 0);
    run_row(10, 1'b1, 10, 1'b1, 1'b0, 1'b0, 224, 1'b0, 1'b1, 96, 0);
    run_row(140, 1'b0, 140, 1'b0, 1'b0, 1'b0, 288, 1'b0, 1'b0, 96, 1);
    run_row(10, 1'b1, 50, 1'b0, 1'b0, 1'b0, 224, 1'b0, 1'b0, 96, 0);
    run_row(10, 1'b1, 10, 1'b1, 1'b0, 1'b0, 224, 1'b0, 1'b1, 96, 0);
    run_row(40, 1'b0, 40, 1'b0, 1'b1, 1'b0, 224, 1'b0, 1'b0, 96, 0);
    run_row(10, 1'b1, 10, 1'b1, 1'b0, 1'b0, 224, 1'b0, 1'b1, 96, 0);
    run_row(234, 1'b0, 234, 1'b0, 1'b0, 1'b0, 224, 1'b0, 1'b1, 32, 1);
    // Single sampling: same lengths, so the late rising edge alone decides the bit.
    // The write costs two edges, so the row's offsets and first count are two less.
    @(posedge clock);
    config_mode <= 1'b1;
    timing_cfg <= '{6'h0f, 2'h1, 3'h1, 3'h3, 3'h2, 1'b0, 1'b1};
    @(posedge clock);
    config_mode <= 1'b0;
    run_row(214, 1'b1, 214, 1'b1, 1'b0, 1'b0, 222, 1'b0, 1'b1, 96, 0);
    report_and_stop;
  end
endmodule
